// ### inc/mitc_core_map.vh
// Constants for the instruction timing core: opcodes, fields and timing.
`ifndef MITC_CORE_MAP_VH
`define MITC_CORE_MAP_VH
`define MITC_CLKS_PER_CYCLE 3'd4
`define MITC_PHASE_LAST 2'd3
`define MITC_OP_HI 15
`define MITC_OP_LO 10
`define MITC_OP_MOV_A_M 6'h00
`define MITC_OP_MOV_M_A 6'h01
`define MITC_OP_MOV_A_X 6'h02
`define MITC_OP_ADD_A_M 6'h03
`define MITC_OP_ADD_A_X 6'h04
`define MITC_OP_ADC_A_M 6'h05
`define MITC_OP_SUB_A_M 6'h06
`define MITC_OP_SUB_A_X 6'h07
`define MITC_OP_SBC_A_M 6'h08
`define MITC_OP_AND_A_M 6'h09
`define MITC_OP_OR_A_M 6'h0A
`define MITC_OP_XOR_A_M 6'h0B
`define MITC_OP_INV_M 6'h0C
`define MITC_OP_INV_A 6'h0D
`define MITC_OP_INC_M 6'h0E
`define MITC_OP_INC_A 6'h0F
`define MITC_OP_DEC_M 6'h10
`define MITC_OP_DEC_A 6'h11
`define MITC_OP_RR_M 6'h12
`define MITC_OP_RL_M 6'h13
`define MITC_OP_RRCY_M 6'h14
`define MITC_OP_RLCY_M 6'h15
`define MITC_OP_SET_BIT 6'h16
`define MITC_OP_CLR_BIT 6'h17
`define MITC_OP_SZ_M 6'h18
`define MITC_OP_SZ_BIT 6'h19
`define MITC_OP_SNZ_BIT 6'h1A
`define MITC_OP_JUMP 6'h1B
`define MITC_OP_CALL 6'h1C
`define MITC_OP_RET 6'h1D
`define MITC_OP_RET_IRQ 6'h1E
`define MITC_OP_TABRD 6'h1F
`define MITC_OP_HALT 6'h20
`define MITC_OP_CLRWDT 6'h21
`define MITC_OP_NOP 6'h3F
`define MITC_ADDR_PC_LOW 8'h02
`define MITC_FLAG_Z 0
`define MITC_FLAG_C 1
`define MITC_FLAG_AC 2
`define MITC_FLAG_OV 3
`endif

// ### hw/mitc_phase_gen.v
// Four-phase generator that frames one instruction cycle.
`timescale 1ns/100ps
`include "mitc_core_map.vh"
module mitc_phase_gen (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Phase outputs.
  output reg [1:0] phase,
  output reg cycleEnd
);
  always @(posedge ref_clk) begin
    if (rst) begin
      phase <= 2'd0;
      cycleEnd <= 1'b0;
    end else begin
      phase <= phase + 2'd1;
      cycleEnd <= (phase == `MITC_PHASE_LAST - 2'd1);
    end
  end
endmodule // mitc_phase_gen

// ### hw/mitc_core.v
// Instruction execution and timing core.
`timescale 1ns/100ps
`include "mitc_core_map.vh"
module mitc_core #(
  parameter PC_WIDTH = 11,
  parameter STACK_DEPTH = 4,
  parameter DMEM_DEPTH = 256
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Program memory.
  output reg [PC_WIDTH-1:0] progAddr,
  input wire [15:0] progData,
  // Status outputs.
  output reg [7:0] accumulatorOut,
  output reg [3:0] flagsOut,
  output reg globalIrqEnable,
  output reg powerDown,
  output reg watchdogClear,
  output reg [7:0] tableLowOut,
  output reg [7:0] tableHighOut,
  output reg [PC_WIDTH-1:0] pcOut
);
  // ****************************************************************
  // Phase generator.
  // ****************************************************************
  wire [1:0] phase;
  wire cycleEnd;
  mitc_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst(rst),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );
  // ****************************************************************
  // State.
  // ****************************************************************
  reg [7:0] dataMem [0:DMEM_DEPTH-1];
  reg [PC_WIDTH-1:0] stackMem [0:STACK_DEPTH-1];
  reg [1:0] stackPtr_reg;
  reg [PC_WIDTH-1:0] pc_reg;
  reg [15:0] instr_reg;
  reg flush_reg;
  reg [7:0] accumulator_reg;
  reg [3:0] flags_reg;
  reg tableFetch_reg;
  integer i;
  // ****************************************************************
  // Arithmetic helper.
  // ****************************************************************
  function [11:0] mitc_addsub;
    input [7:0] a;
    input [7:0] b;
    input cin;
    input sub;
    reg [7:0] bb;
    reg [8:0] s;
    reg [4:0] h;
    begin
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      mitc_addsub = {s[7:0], (a[7] == bb[7]) && (s[7] != a[7]),
        h[4], s[8], (s[7:0] == 8'h00)};
    end
  endfunction
  // ****************************************************************
  // Decode and execute.
  // ****************************************************************
  wire [5:0] opcode = instr_reg[`MITC_OP_HI:`MITC_OP_LO];
  wire [7:0] addrM = instr_reg[7:0];
  wire [2:0] bitSel = instr_reg[10:8];
  wire [7:0] memVal = dataMem[addrM];
  reg [7:0] accNext;
  reg [7:0] memNext;
  reg memWrite;
  reg [3:0] flagsNext;
  reg [11:0] arith;
  reg takeBranch;
  reg [PC_WIDTH-1:0] target;
  reg push;
  reg pop;
  reg irqNext;
  reg haltNext;
  reg wdtNext;
  reg tableNext;
  always @* begin
    accNext = accumulator_reg;
    memNext = memVal;
    memWrite = 1'b0;
    flagsNext = flags_reg;
    arith = 12'h000;
    takeBranch = 1'b0;
    target = pc_reg;
    push = 1'b0;
    pop = 1'b0;
    irqNext = globalIrqEnable;
    haltNext = 1'b0;
    wdtNext = 1'b0;
    tableNext = 1'b0;
    if (!flush_reg && !tableFetch_reg) begin
      case (opcode)
        `MITC_OP_MOV_A_M: accNext = memVal;
        `MITC_OP_MOV_M_A: begin
          memNext = accumulator_reg;
          memWrite = 1'b1;
        end
        `MITC_OP_MOV_A_X: accNext = addrM;
        `MITC_OP_ADD_A_M, `MITC_OP_ADD_A_X, `MITC_OP_ADC_A_M,
        `MITC_OP_SUB_A_M, `MITC_OP_SUB_A_X, `MITC_OP_SBC_A_M: begin
          arith = mitc_addsub(accumulator_reg,
            (opcode == `MITC_OP_ADD_A_X || opcode == `MITC_OP_SUB_A_X) ?
            addrM : memVal,
            (opcode == `MITC_OP_ADC_A_M || opcode == `MITC_OP_SBC_A_M) ?
            flags_reg[`MITC_FLAG_C] :
            (opcode == `MITC_OP_SUB_A_M || opcode == `MITC_OP_SUB_A_X),
            (opcode == `MITC_OP_SUB_A_M || opcode == `MITC_OP_SUB_A_X ||
            opcode == `MITC_OP_SBC_A_M));
          accNext = arith[11:4];
          flagsNext = arith[3:0];
        end
        `MITC_OP_AND_A_M, `MITC_OP_OR_A_M, `MITC_OP_XOR_A_M: begin
          accNext = (opcode == `MITC_OP_AND_A_M) ? accumulator_reg & memVal :
            (opcode == `MITC_OP_OR_A_M) ? accumulator_reg | memVal :
            accumulator_reg ^ memVal;
          flagsNext[`MITC_FLAG_Z] = (accNext == 8'h00);
        end
        `MITC_OP_INV_M: begin
          memNext = ~memVal;
          memWrite = 1'b1;
          flagsNext[`MITC_FLAG_Z] = (memNext == 8'h00);
        end
        `MITC_OP_INV_A: begin
          accNext = ~memVal;
          flagsNext[`MITC_FLAG_Z] = (accNext == 8'h00);
        end
        `MITC_OP_INC_M, `MITC_OP_DEC_M: begin
          memNext = (opcode == `MITC_OP_INC_M) ? memVal + 8'h01 :
            memVal - 8'h01;
          memWrite = 1'b1;
          flagsNext[`MITC_FLAG_Z] = (memNext == 8'h00);
        end
        `MITC_OP_INC_A, `MITC_OP_DEC_A: begin
          accNext = (opcode == `MITC_OP_INC_A) ? memVal + 8'h01 :
            memVal - 8'h01;
          flagsNext[`MITC_FLAG_Z] = (accNext == 8'h00);
        end
        `MITC_OP_RR_M: begin
          memNext = {memVal[0], memVal[7:1]};
          memWrite = 1'b1;
        end
        `MITC_OP_RL_M: begin
          memNext = {memVal[6:0], memVal[7]};
          memWrite = 1'b1;
        end
        `MITC_OP_RRCY_M: begin
          memNext = {flags_reg[`MITC_FLAG_C], memVal[7:1]};
          flagsNext[`MITC_FLAG_C] = memVal[0];
          memWrite = 1'b1;
        end
        `MITC_OP_RLCY_M: begin
          memNext = {memVal[6:0], flags_reg[`MITC_FLAG_C]};
          flagsNext[`MITC_FLAG_C] = memVal[7];
          memWrite = 1'b1;
        end
        `MITC_OP_SET_BIT, `MITC_OP_CLR_BIT: begin
          memNext = memVal;
          memNext[bitSel] = (opcode == `MITC_OP_SET_BIT);
          memWrite = 1'b1;
        end
        `MITC_OP_SZ_M: begin
          takeBranch = (memVal == 8'h00);
          target = pc_reg + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
        `MITC_OP_SZ_BIT, `MITC_OP_SNZ_BIT: begin
          takeBranch = memVal[bitSel] ^ (opcode == `MITC_OP_SZ_BIT);
          target = pc_reg + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
        `MITC_OP_JUMP: begin
          takeBranch = 1'b1;
          target = instr_reg[PC_WIDTH-1:0];
        end
        `MITC_OP_CALL: begin
          takeBranch = 1'b1;
          target = instr_reg[PC_WIDTH-1:0];
          push = 1'b1;
        end
        `MITC_OP_RET, `MITC_OP_RET_IRQ: begin
          takeBranch = 1'b1;
          target = stackMem[stackPtr_reg - 2'd1];
          pop = 1'b1;
          if (opcode == `MITC_OP_RET_IRQ) begin
            irqNext = 1'b1;
          end
        end
        `MITC_OP_TABRD: begin
          tableNext = 1'b1;
        end
        `MITC_OP_HALT: haltNext = 1'b1;
        `MITC_OP_CLRWDT: wdtNext = 1'b1;
        default: accNext = accumulator_reg;
      endcase
      if (memWrite && addrM == `MITC_ADDR_PC_LOW) begin
        takeBranch = 1'b1;
        target = {pc_reg[PC_WIDTH-1:8], memNext};
        memWrite = 1'b0;
      end
    end
  end
  // ****************************************************************
  // Sequencing: one instruction per four clocks.
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      pc_reg <= {PC_WIDTH{1'b0}};
      instr_reg <= {`MITC_OP_NOP, 10'h000};
      flush_reg <= 1'b1;
      accumulator_reg <= 8'h00;
      flags_reg <= 4'h0;
      stackPtr_reg <= 2'd0;
      tableFetch_reg <= 1'b0;
      progAddr <= {PC_WIDTH{1'b0}};
      globalIrqEnable <= 1'b0;
      powerDown <= 1'b0;
      watchdogClear <= 1'b0;
      tableLowOut <= 8'h00;
      tableHighOut <= 8'h00;
      accumulatorOut <= 8'h00;
      flagsOut <= 4'h0;
      pcOut <= {PC_WIDTH{1'b0}};
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stackMem[i] <= {PC_WIDTH{1'b0}};
      end
    end else begin
      watchdogClear <= 1'b0;
      if (cycleEnd && !powerDown) begin
        // The table word takes the fetch slot, so the held word waits.
        if (tableFetch_reg) begin
          tableLowOut <= progData[7:0];
          tableHighOut <= progData[15:8];
        end else begin
          instr_reg <= progData;
        end
        flush_reg <= takeBranch;
        tableFetch_reg <= tableNext;
        accumulator_reg <= accNext;
        accumulatorOut <= accNext;
        flags_reg <= flagsNext;
        flagsOut <= flagsNext;
        globalIrqEnable <= irqNext;
        powerDown <= haltNext;
        watchdogClear <= wdtNext;
        if (memWrite) begin
          dataMem[addrM] <= memNext;
        end
        if (push) begin
          stackMem[stackPtr_reg] <= pc_reg;
          stackPtr_reg <= stackPtr_reg + 2'd1;
        end else if (pop) begin
          stackPtr_reg <= stackPtr_reg - 2'd1;
        end
        if (tableNext) begin
          progAddr <= {{(PC_WIDTH-8){1'b1}}, accumulator_reg};
        end else if (takeBranch) begin
          progAddr <= target;
          pc_reg <= target;
        end else begin
          progAddr <= pc_reg + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          pc_reg <= pc_reg + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
        if (!flush_reg && !tableFetch_reg) begin
          pcOut <= pc_reg - {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // mitc_core

// ### testbench/mitc_prog_mem.sv
// Program memory model feeding instruction and table words to the core.
`timescale 1ns/100ps
module mitc_prog_mem #(
  parameter PC_WIDTH = 10
) (
  // Read port.
  input wire logic [PC_WIDTH-1:0] progAddr,
  output wire logic [15:0] progData
);
  logic [15:0] mem [0:(1<<PC_WIDTH)-1];
  // The word follows the address at once and holds while it is stable.
  assign progData = mem[progAddr];
endmodule // mitc_prog_mem

// ### testbench/mitc_core_assertions.sv
// Port checker for the instruction timing core.
`timescale 1ns/100ps
module mitc_core_assertions #(
  parameter PC_WIDTH = 11
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Observed ports.
  input wire logic [PC_WIDTH-1:0] progAddr,
  input wire logic [7:0] accumulatorOut,
  input wire logic [3:0] flagsOut,
  input wire logic globalIrqEnable,
  input wire logic powerDown,
  input wire logic watchdogClear,
  input wire logic [7:0] tableLowOut,
  input wire logic [PC_WIDTH-1:0] pcOut
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_halt_sticky: assert property (powerDown |=> powerDown)
    else $error("power down dropped");
  a_wdc_pulse: assert property (watchdogClear |=> !watchdogClear)
    else $error("watchdog clear longer than one clock");
  a_halt_frozen: assert property ($past(powerDown) |-> $stable(pcOut))
    else $error("program counter moved after halt");
  a_pc_cycle_hold: assert property (
    $changed(pcOut) |=> $stable(pcOut) [*3])
    else $error("pc changed inside an instruction cycle");
  a_acc_cycle_hold: assert property (
    $changed(accumulatorOut) |=> $stable(accumulatorOut) [*3])
    else $error("accumulator changed inside an instruction cycle");
  a_flag_cycle_hold: assert property (
    $changed(flagsOut) |=> $stable(flagsOut) [*3])
    else $error("flags changed inside an instruction cycle");
  a_addr_cycle_hold: assert property (
    $changed(progAddr) |=> $stable(progAddr) [*3])
    else $error("fetch address changed inside an instruction cycle");
  a_table_cycle_hold: assert property (
    $changed(tableLowOut) |=> $stable(tableLowOut) [*3])
    else $error("table byte changed inside an instruction cycle");
  a_reset_clears_out: assert property (disable iff (1'b0)
    rst |=> accumulatorOut == 8'h00 && flagsOut == 4'h0 && !powerDown)
    else $error("outputs not cleared by reset");
  c_halt: cover property ($rose(powerDown));
  c_wdc: cover property (watchdogClear);
  c_gie: cover property ($rose(globalIrqEnable));
endmodule // mitc_core_assertions
bind mitc_core mitc_core_assertions #(.PC_WIDTH(PC_WIDTH)) chk (
  .ref_clk(ref_clk), .rst(rst), .progAddr(progAddr),
  .accumulatorOut(accumulatorOut), .flagsOut(flagsOut),
  .globalIrqEnable(globalIrqEnable), .powerDown(powerDown),
  .watchdogClear(watchdogClear), .tableLowOut(tableLowOut), .pcOut(pcOut));

// ### testbench/testbench.sv
// Self-checking bench for the instruction timing core.
`timescale 1ns/100ps
`include "mitc_core_map.vh"
module testbench;
  // ****************
  // Signals and opcodes
  // ****************
  localparam [5:0] oMvi = `MITC_OP_MOV_A_X, oMvm = `MITC_OP_MOV_M_A,
    oMam = `MITC_OP_MOV_A_M, oAdi = `MITC_OP_ADD_A_X,
    oSbi = `MITC_OP_SUB_A_X, oXor = `MITC_OP_XOR_A_M,
    oRlcy = `MITC_OP_RLCY_M, oRr = `MITC_OP_RR_M, oIncA = `MITC_OP_INC_A,
    oSet = `MITC_OP_SET_BIT, oClr = `MITC_OP_CLR_BIT, oSz = `MITC_OP_SZ_M,
    oGo = `MITC_OP_JUMP, oCall = `MITC_OP_CALL, oRet = `MITC_OP_RET,
    oRti = `MITC_OP_RET_IRQ, oTab = `MITC_OP_TABRD, oWdc = `MITC_OP_CLRWDT;
  localparam [15:0] H = {`MITC_OP_HALT, 10'h000};
  typedef struct packed {
    logic [79:0] pg;
    logic [7:0] a;
    logic [3:0] fm;
    logic [3:0] fv;
    int n;
  } mitc_row_t;
  logic ref_clk, rst, globalIrqEnable, powerDown, watchdogClear, wdSeen;
  logic [9:0] progAddr, pcOut, pcHeld;
  logic [15:0] progData;
  logic [7:0] accumulatorOut, tableLowOut, tableHighOut;
  logic [3:0] flagsOut;
  int fails = 0, checked = 0, clks, t0 = 2 * `MITC_CLKS_PER_CYCLE, cyc = 0;
  mitc_row_t rows [14] = '{
    '{{H, H, H, H, H}, 8'h00, 4'h0, 4'h0, 0},
    '{{{oMvi, 10'h080}, {oAdi, 10'h080}, H, H, H}, 8'h00, 4'hF, 4'hB, 2},
    '{{{oMvi, 10'h000}, {oSbi, 10'h001}, H, H, H}, 8'hFF, 4'h3, 4'h0, 2},
    '{{{oMvi, 10'h05A}, {oMvm, 10'h010}, {oXor, 10'h010}, H, H},
      8'h00, 4'h1, 4'h1, 3},
    '{{{oMvi, 10'h081}, {oMvm, 10'h010}, {oRlcy, 10'h010}, {oMam, 10'h010},
      H}, 8'h02, 4'h2, 4'h2, 4},
    '{{{oMvi, 10'h001}, {oMvm, 10'h011}, {oRr, 10'h011}, {oMam, 10'h011},
      H}, 8'h80, 4'h0, 4'h0, 4},
    '{{{oMvi, 10'h0FF}, {oMvm, 10'h012}, {oIncA, 10'h012}, H, H},
      8'h00, 4'h1, 4'h1, 3},
    '{{{oMvi, 10'h0F0}, {oMvm, 10'h013}, {oSet, 10'h213}, {oClr, 10'h113},
      {oMam, 10'h013}}, 8'hD4, 4'h0, 4'h0, 5},
    '{{{oGo, 10'h003}, {oMvi, 10'h011}, {oMvi, 10'h022}, H, H},
      8'h00, 4'h0, 4'h0, 2},
    '{{{oCall, 10'h004}, {oMvi, 10'h033}, H, H, {oRet, 10'h000}},
      8'h33, 4'h0, 4'h0, 5},
    '{{{oMvi, 10'h000}, {oMvm, 10'h014}, {oSz, 10'h014}, {oMvi, 10'h044},
      H}, 8'h00, 4'h0, 4'h0, 4},
    '{{{oMvi, 10'h001}, {oMvm, 10'h014}, {oSz, 10'h014}, {oMvi, 10'h055},
      H}, 8'h55, 4'h0, 4'h0, 4},
    '{{{oMvi, 10'h003}, {oMvm, 2'b00, `MITC_ADDR_PC_LOW}, {oMvi, 10'h066}, H,
      H}, 8'h03, 4'h0, 4'h0, 3},
    '{{{oMvi, 10'h005}, {oTab, 10'h000}, H, H, H}, 8'h05, 4'h0, 4'h0, 3}
  };
  mitc_core #(.PC_WIDTH(10)) dut (.ref_clk(ref_clk), .rst(rst),
    .progAddr(progAddr), .progData(progData),
    .accumulatorOut(accumulatorOut), .flagsOut(flagsOut),
    .globalIrqEnable(globalIrqEnable), .powerDown(powerDown),
    .watchdogClear(watchdogClear), .tableLowOut(tableLowOut),
    .tableHighOut(tableHighOut), .pcOut(pcOut));
  mitc_prog_mem #(.PC_WIDTH(10)) pm (.progAddr(progAddr),
    .progData(progData));
  // ****************
  // Tasks
  // ****************
  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_prog(input logic [79:0] pg);
    int i;
    @(posedge ref_clk);
    rst <= 1'b1;
    for (i = 0; i < 1024; i++) pm.mem[i] = H;
    for (i = 0; i < 5; i++) pm.mem[i] = pg[79-16*i -: 16];
    pm.mem[10'h305] = 16'hBEEF;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    clks = 0;
    do begin
      @(posedge ref_clk);
      #1;
      clks++;
    end while (powerDown !== 1'b1 && clks < 400);
  endtask
  // ****************
  // Clock, timeout and sequence
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (watchdogClear === 1'b1) wdSeen <= 1'b1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1;
    wdSeen = 1'b0;
    foreach (rows[r]) begin
      run_prog(rows[r].pg);
      chk_cnt(clks, t0 + 4 * rows[r].n);
      chk_val(accumulatorOut, rows[r].a);
      chk_val({4'h0, flagsOut & rows[r].fm}, {4'h0, rows[r].fv});
      chk_val({7'h00, globalIrqEnable}, 8'h00);
      $display("row %0d done", r);
    end
    chk_val(tableHighOut, 8'hBE);
    chk_val(tableLowOut, 8'hEF);
    $display("table read test done");
    run_prog({{oWdc, 10'h000}, {oCall, 10'h003}, H, {oRti, 10'h000}, H});
    chk_cnt(clks, t0 + 4 * 5);
    chk_val({7'h00, globalIrqEnable}, 8'h01);
    chk_val({7'h00, wdSeen}, 8'h01);
    chk_val(pcOut[7:0], 8'h02);
    pcHeld = pcOut;
    repeat (20) @(posedge ref_clk);
    #1;
    chk_val({7'h00, powerDown}, 8'h01);
    chk_val(pcOut[7:0], pcHeld[7:0]);
    $display("interrupt return and halt test done");
    end_sim();
  end
endmodule // testbench
